/* File: src/touch_sense_consts.svh */
/*
 Constants for the touch-sense clock, line select and interrupt block.
 Assumes inclusion by bare name from the design file only.
*/
`ifndef TOUCH_SENSE_CONSTS_SVH
`define TOUCH_SENSE_CONSTS_SVH

// Clock chain divide factors less one
`define RC_DIV_LAST      2'h2
`define ADC_DIV_LAST     2'h3
// Reset values
`define PRESC_RST        2'h0
`define CONV_LEN_RST     8'h1E
`define CHARGE_LEN_RST   8'h04
// Interrupt request count
`define REQ_COUNT        4

`endif

/* File: src/touch_sense_pkg.sv */
/*
 Types shared by the touch-sense block.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package touch_sense_pkg;
	// Sequencer phase, one-hot
	typedef enum logic [2:0] {
		SEQ_IDLE   = 3'b001,
		SEQ_CHARGE = 3'b010,
		SEQ_SENSE  = 3'b100
	} seq_state_e;
endpackage
`default_nettype wire

/* File: src/touch_sense_clock_io_irq.sv */
/*
 Touch-sense digital side: RC clock divide, prescaler, converter clock,
 conversion pacing, pad handover, charge/sense sequencing and the merged
 host interrupt. Assumes RC_SRC_CLK is asynchronous; every other input is
 driven from logic on CORE_CLK.
*/
// Function
// - RC source divided by three gives 4 MHz
// - Prescale 4 MHz by 1, 2, 4 or 8
// - Converter clock is prescaled clock over four
// - Conversion rate set by timing configuration
// - Active subsystem and selected line makes pad analogue
// - Disabled line releases pad for other use
// - Separate select bit per X and Y line
// - Sequencer drives charge and sense pulses automatically
// - Four distinct host interface interrupt requests
// - Interrupt output is OR of four requests
`include "touch_sense_consts.svh"
`default_nettype none
module touch_sense_clock_io_irq
	import touch_sense_pkg::*;
#(
	parameter int NUM_X = 8,
	parameter int NUM_Y = 8
) (
	input  wire logic             CORE_CLK,
	input  wire logic             RST,
	input  wire logic             CE,
	input  wire logic             RC_SRC_CLK,
	input  wire logic             SUBSYS_EN,
	input  wire logic [1:0]       PRESC_SEL,
	input  wire logic [7:0]       CONV_LEN,
	input  wire logic [7:0]       CHARGE_LEN,
	input  wire logic [NUM_X-1:0] X_SEL,
	input  wire logic [NUM_Y-1:0] Y_SEL,
	input  wire logic [3:0]       REQ_SET,
	input  wire logic [3:0]       REQ_CLR,
	output logic                  BASE_TICK,
	output logic                  TOUCH_CTRL_TICK,
	output logic                  ADC_CLK_TICK,
	output logic                  SAMPLE_DONE,
	output logic [NUM_X-1:0]      X_PAD_ANALOG,
	output logic [NUM_Y-1:0]      Y_PAD_ANALOG,
	output logic [NUM_X-1:0]      X_CHARGE,
	output logic [NUM_Y-1:0]      Y_SENSE,
	output logic [3:0]            HOST_IF_REQ,
	output logic                  TOUCH_IRQ
);

	initial begin
		if (NUM_X < 1 || NUM_Y < 1 || NUM_X > 32 || NUM_Y > 32)
			$error("Line counts must be 1 to 32");
	end

	logic             rc_s1_ff, rc_s2_ff, rc_s3_ff;
	logic [1:0]       rc_cnt_ff;
	logic             base_tick_ff;
	logic [1:0]       presc_ff;
	logic [2:0]       presc_cnt_ff;
	logic             ctrl_tick_ff;
	logic [1:0]       adc_cnt_ff;
	logic             adc_tick_ff;
	logic [7:0]       ph_cnt_ff;
	logic             done_ff;
	seq_state_e       state_ff;
	logic [NUM_X-1:0] x_sel_ff, x_pad_ff, x_chg_ff;
	logic [NUM_Y-1:0] y_sel_ff, y_pad_ff, y_sns_ff;
	logic [3:0]       req_ff, nxt_req;
	logic             irq_ff;
	logic             rc_rise;
	logic [2:0]       presc_last;
	logic             any_sel;

	// Two-flop sync of the RC clock; third flop only for edge detect
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rc_s1_ff <= 1'b0;
			rc_s2_ff <= 1'b0;
			rc_s3_ff <= 1'b0;
		end else if (CE) begin
			rc_s1_ff <= RC_SRC_CLK;
			rc_s2_ff <= rc_s1_ff;
			rc_s3_ff <= rc_s2_ff;
		end
	end
	assign rc_rise = rc_s2_ff & ~rc_s3_ff;

	// Every third RC edge gives one 4 MHz tick; needs CORE_CLK > 2x RC
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rc_cnt_ff    <= 2'h0;
			base_tick_ff <= 1'b0;
		end else if (CE) begin
			base_tick_ff <= rc_rise && (rc_cnt_ff == `RC_DIV_LAST);
			if (rc_rise)
				rc_cnt_ff <= (rc_cnt_ff == `RC_DIV_LAST) ? 2'h0 : rc_cnt_ff + 2'h1;
		end
	end

	// Ratio taken once per prescaler cycle boundary is not needed; a live
	// change just restarts the count cleanly
	assign presc_last = 3'(({1'b0, 2'h0} + 3'h1) << presc_ff) - 3'h1;

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			presc_ff     <= `PRESC_RST;
			presc_cnt_ff <= 3'h0;
			ctrl_tick_ff <= 1'b0;
		end else if (CE) begin
			presc_ff     <= PRESC_SEL;
			ctrl_tick_ff <= base_tick_ff && (presc_cnt_ff >= presc_last);
			if (presc_ff != PRESC_SEL)
				presc_cnt_ff <= 3'h0;
			else if (base_tick_ff)
				presc_cnt_ff <= (presc_cnt_ff >= presc_last) ? 3'h0 : presc_cnt_ff + 3'h1;
		end
	end

	// Converter clock: one tick per four controller ticks
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			adc_cnt_ff  <= 2'h0;
			adc_tick_ff <= 1'b0;
		end else if (CE) begin
			adc_tick_ff <= ctrl_tick_ff && (adc_cnt_ff == `ADC_DIV_LAST);
			if (ctrl_tick_ff)
				adc_cnt_ff <= adc_cnt_ff + 2'h1;
		end
	end

	// Line selects and pad handover; a pad leaves analogue on the clock after disable or deselect
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			x_sel_ff <= '0;
			y_sel_ff <= '0;
			x_pad_ff <= '0;
			y_pad_ff <= '0;
		end else if (CE) begin
			x_sel_ff <= X_SEL;
			y_sel_ff <= Y_SEL;
			x_pad_ff <= SUBSYS_EN ? X_SEL : '0;
			y_pad_ff <= SUBSYS_EN ? Y_SEL : '0;
		end
	end
	assign any_sel = (|x_sel_ff) | (|y_sel_ff);

	// Sequencer: charge phase then sense phase; a conversion spans
	// CONV_LEN+2 converter ticks, which sets the data rate
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_ff  <= SEQ_IDLE;
			ph_cnt_ff <= 8'h00;
			done_ff   <= 1'b0;
		end else if (CE) begin
			done_ff <= 1'b0;
			if (!SUBSYS_EN || !any_sel) begin
				state_ff  <= SEQ_IDLE; // Abandon on disable, no result
				ph_cnt_ff <= 8'h00;
			end else if (adc_tick_ff) begin
				unique case (state_ff)
					SEQ_IDLE: begin
						state_ff  <= SEQ_CHARGE;
						ph_cnt_ff <= 8'h00;
					end
					SEQ_CHARGE: begin
						ph_cnt_ff <= ph_cnt_ff + 8'h01;
						if (ph_cnt_ff + 8'h01 >= CHARGE_LEN)
							state_ff <= SEQ_SENSE;
					end
					SEQ_SENSE: begin
						if (ph_cnt_ff >= CONV_LEN) begin
							state_ff  <= SEQ_IDLE;
							ph_cnt_ff <= 8'h00;
							done_ff   <= 1'b1;
						end else begin
							ph_cnt_ff <= ph_cnt_ff + 8'h01;
						end
					end
				endcase
			end
		end
	end

	// Pulses go only to selected lines of an active subsystem
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			x_chg_ff <= '0;
			y_sns_ff <= '0;
		end else if (CE) begin
			x_chg_ff <= (SUBSYS_EN && state_ff == SEQ_CHARGE) ? X_SEL : '0;
			y_sns_ff <= (SUBSYS_EN && state_ff == SEQ_SENSE) ? Y_SEL : '0;
		end
	end

	// Sticky requests; set beats clear; request 0 also marks a result
	always_comb begin
		nxt_req = (req_ff & ~REQ_CLR) | REQ_SET;
		nxt_req[0] = nxt_req[0] | done_ff;
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			req_ff <= 4'h0;
			irq_ff <= 1'b0;
		end else if (CE) begin
			req_ff <= nxt_req;
			irq_ff <= |nxt_req;
		end
	end

	assign BASE_TICK       = base_tick_ff;
	assign TOUCH_CTRL_TICK = ctrl_tick_ff;
	assign ADC_CLK_TICK    = adc_tick_ff;
	assign SAMPLE_DONE     = done_ff;
	assign X_PAD_ANALOG    = x_pad_ff;
	assign Y_PAD_ANALOG    = y_pad_ff;
	assign X_CHARGE        = x_chg_ff;
	assign Y_SENSE         = y_sns_ff;
	assign HOST_IF_REQ     = req_ff;
	assign TOUCH_IRQ       = irq_ff;

	// Checks
	property p_rc_div;
		@(posedge CORE_CLK) disable iff (RST)
		(base_tick_ff && $past(CE)) |-> $past(rc_cnt_ff) == 2'h2 && $past(rc_rise);
	endproperty
	a_rc_div: assert property (p_rc_div) else $error("RC divide wrong");

	property p_presc;
		@(posedge CORE_CLK) disable iff (RST)
		(CE && base_tick_ff && presc_ff == PRESC_SEL && presc_cnt_ff == presc_last)
			|=> ctrl_tick_ff;
	endproperty
	a_presc: assert property (p_presc) else $error("Prescaler tick missed");

	property p_adc_div;
		@(posedge CORE_CLK) disable iff (RST)
		adc_tick_ff |-> $past(ctrl_tick_ff) && adc_cnt_ff == 2'h0;
	endproperty
	a_adc_div: assert property (p_adc_div) else $error("Converter divide wrong");

	property p_rate;
		@(posedge CORE_CLK) disable iff (RST)
		done_ff |-> $past(state_ff) == SEQ_SENSE && $past(ph_cnt_ff) >= $past(CONV_LEN);
	endproperty
	a_rate: assert property (p_rate) else $error("Early conversion end");

	property p_pad_on;
		@(posedge CORE_CLK) disable iff (RST)
		(CE && SUBSYS_EN) |=> X_PAD_ANALOG == $past(X_SEL) && Y_PAD_ANALOG == $past(Y_SEL);
	endproperty
	a_pad_on: assert property (p_pad_on) else $error("Pad not analogue");

	property p_pad_off;
		@(posedge CORE_CLK) disable iff (RST)
		(CE && !SUBSYS_EN) |=> X_PAD_ANALOG == '0 && Y_PAD_ANALOG == '0;
	endproperty
	a_pad_off: assert property (p_pad_off) else $error("Pad not released");

	property p_pulse_sel;
		@(posedge CORE_CLK) disable iff (RST)
		(X_CHARGE & ~X_PAD_ANALOG) == '0 && !(|X_CHARGE && |Y_SENSE);
	endproperty
	a_pulse_sel: assert property (p_pulse_sel) else $error("Pulse on bad line");

	property p_sticky;
		@(posedge CORE_CLK) disable iff (RST)
		(CE && REQ_SET[3]) |=> HOST_IF_REQ[3] ##1 (HOST_IF_REQ[3] || $past(REQ_CLR[3]));
	endproperty
	a_sticky: assert property (p_sticky) else $error("Request lost");

	property p_irq_or;
		@(posedge CORE_CLK) disable iff (RST)
		TOUCH_IRQ == |HOST_IF_REQ;
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("Interrupt not OR");

	property p_reset;
		@(posedge CORE_CLK)
		(RST && CE) |=> presc_ff == 2'h0 && HOST_IF_REQ == 4'h0 && x_sel_ff == '0 && !TOUCH_IRQ;
	endproperty
	a_reset: assert property (p_reset) else $error("Bad reset state");

	c_done: cover property (@(posedge CORE_CLK) disable iff (RST) done_ff);
	c_div8: cover property (@(posedge CORE_CLK) disable iff (RST)
		ctrl_tick_ff && presc_ff == 2'h3);
	c_irq: cover property (@(posedge CORE_CLK) disable iff (RST) $rose(TOUCH_IRQ));
	c_multi: cover property (@(posedge CORE_CLK) disable iff (RST)
		|X_CHARGE && !$onehot(X_CHARGE));

endmodule
`default_nettype wire

/* File: tb/touch_electrodes.sv */
/*
 Electrode model at the touch pads.
 Assumes pads and pulses come from the design on the same clock.
*/
`default_nettype none
module touch_electrodes #(
	parameter int NX = 8,
	parameter int NY = 8
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [NX-1:0] x_pad,
	input  wire logic [NY-1:0] y_pad,
	input  wire logic [NX-1:0] x_chg,
	input  wire logic [NY-1:0] y_sns,
	output logic               misuse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [NX-1:0] xp_ff;
	logic [NY-1:0] yp_ff;
	// Sticky flag; one cycle of slack, though pad and pulse both lag select and enable by one cycle
	always_ff @(posedge clk) begin
		xp_ff <= x_pad;
		yp_ff <= y_pad;
		if (rst)
			misuse <= 1'b0;
		else
			misuse <= misuse | |(x_chg & ~x_pad & ~xp_ff) | |(y_sns & ~y_pad & ~yp_ff);
	end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
 Self-checking bench for the touch-sense block.
 Assumes the design and the electrode model are compiled first.
*/
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst = 1'b1, en = 1'b0, rc = 1'b0, misuse, bt, ct, at, done, irq;
	logic [1:0]  presc = 2'h0;
	logic [7:0]  xs = 8'h00, ys = 8'h00, xp, yp, xc, yse, sx, sy;
	logic [3:0]  rset = 4'h0, rclr = 4'h0, req, mreq;
	logic [31:0] seed = 32'h3575_083e;
	int          fail_count = 0, checks = 0, cyc = 0, clast = 0, cgap = 0;
	int          alast = 0, agap = 0, acnt = 0, n, blast = 0, bgap = 0;

	always #2 clk = ~clk;
	// RC source at six core cycles, off the core edges
	initial begin
		#1;
		forever #12 rc = ~rc;
	end

	touch_sense_clock_io_irq i_touch_sense_clock_io_irq (
		.CORE_CLK(clk), .RST(rst), .CE(1'b1), .RC_SRC_CLK(rc), .SUBSYS_EN(en),
		.PRESC_SEL(presc), .CONV_LEN(8'h06), .CHARGE_LEN(8'h02), .X_SEL(xs),
		.Y_SEL(ys), .REQ_SET(rset), .REQ_CLR(rclr), .BASE_TICK(bt),
		.TOUCH_CTRL_TICK(ct), .ADC_CLK_TICK(at), .SAMPLE_DONE(done),
		.X_PAD_ANALOG(xp), .Y_PAD_ANALOG(yp), .X_CHARGE(xc), .Y_SENSE(yse),
		.HOST_IF_REQ(req), .TOUCH_IRQ(irq)
	);
	touch_electrodes i_touch_electrodes (
		.clk(clk), .rst(rst), .x_pad(xp), .y_pad(yp), .x_chg(xc), .y_sns(yse),
		.misuse(misuse)
	);

	// Tick spacing in core cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (bt) begin
			bgap <= cyc - blast;
			blast <= cyc;
		end
		if (ct) begin
			cgap <= cyc - clast;
			clast <= cyc;
		end
		if (at) begin
			agap <= cyc - alast;
			alast <= cyc;
			acnt <= acnt + 1;
		end
	end

	function automatic logic [31:0] xr(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic [7:0] pad_exp(input logic e, input logic [7:0] s);
		return e ? s : 8'h00;
	endfunction
	// Set beats clear in the same cycle
	function automatic logic [3:0] req_exp(input logic [3:0] r, s, c);
		return (r & ~c) | s;
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		if (fail_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard, well past the expected run
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		report_and_stop;
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({req, irq, xp, yp, xc, yse}, 0);
		// Every ratio; early gaps skipped since the counts restart
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			presc <= s[1:0];
			n = acnt;
			for (int k = 0; k < 2000 && acnt < n + 3; k++)
				@(posedge clk);
			chk(bgap, 18);
			chk(cgap, 18 << s);
			chk(agap, 72 << s);
		end
		// Random selects, all lines at once first
		for (int k = 0; k < 24; k++) begin
			@(posedge clk);
			seed = xr(seed);
			en <= (k == 0) | seed[0];
			xs <= (k == 0) ? 8'hff : seed[15:8];
			ys <= (k == 0) ? 8'hff : seed[23:16];
			repeat (2) @(posedge clk);
			#1;
			chk({xp, yp}, {pad_exp(en, xs), pad_exp(en, ys)});
		end
		@(posedge clk);
		en <= 1'b0;
		rclr <= 4'hf;
		repeat (3) @(posedge clk);
		mreq = 4'h0;
		for (int k = 0; k < 40; k++) begin
			seed = xr(seed);
			rset <= seed[3:0] & seed[7:4];
			rclr <= seed[11:8];
			mreq = req_exp(mreq, seed[3:0] & seed[7:4], seed[11:8]);
			@(posedge clk);
			#1;
			chk({irq, req}, {|mreq, mreq});
			@(posedge clk);
		end
		rset <= 4'h0;
		rclr <= 4'hf;
		xs <= 8'h01;
		ys <= 8'h02;
		en <= 1'b1;
		// Fastest ratio, or eight converter ticks outlast the wait below
		presc <= 2'h0;
		@(posedge clk);
		rclr <= 4'h0;
		sx = 8'h00;
		sy = 8'h00;
		for (int k = 0; k < 3000 && done !== 1'b1; k++) begin
			@(posedge clk);
			#1;
			sx |= xc;
			sy |= yse;
		end
		chk({done, sx, sy}, {1'b1, 8'h01, 8'h02});
		@(posedge clk);
		#1;
		chk(req[0], 1'b1);
		@(posedge clk);
		en <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk({xp, yp, xc, yse, misuse}, 0);
		report_and_stop;
	end
endmodule
`default_nettype wire
